// ===== logic/ubi_pkg.sv
// Constants, register map and field layout of the USB bridge interrupt block
package ubi_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_ENABLE = 4'h4;
	localparam logic [3:0] OFF_CLEAR = 4'h8;
	localparam logic [3:0] OFF_EVENT = 4'hc;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	// Writable enable positions: 29,28,25,24,23..17,10..8
	localparam logic [31:0] ENABLE_MASK = 32'h33fe_0700;
	// Sticky bits this block owns: 29,28,25..17,10,9,8
	localparam logic [31:0] STICKY_MASK = 32'h33fe_0700;
	// Live copies of the core's flags, bits 7..0
	localparam logic [31:0] LIVE_MASK = 32'h0000_00ff;
	localparam int BIT_SETUP = 0;
	localparam int BIT_STATUS_NAK = 1;
	localparam int BIT_STATUS_STAGE = 2;
	localparam int BIT_ZERO_RX = 3;
	localparam int BIT_SOF = 4;
	localparam int BIT_EP0 = 5;
	localparam int BIT_EP = 6;
	localparam int BIT_NAK = 7;
	localparam int BIT_SUSPEND_CHG = 8;
	localparam int BIT_BUS_RESET = 9;
	localparam int BIT_BUS_RESET_END = 10;
	localparam int BIT_CORE_RD_DONE = 24;
	localparam int BIT_CTRL_RD_DONE = 25;
	localparam int BIT_POWER_DETECT = 28;
	localparam int BIT_WRITE_ERROR = 29;
	localparam logic [31:0] RESERVED_READ = 32'h0000_0000;
endpackage

// ===== logic/ubi_edge_detect.sv
// Edge detector for the core's bus-reset and suspend levels
`timescale 1ns/1ps
module ubi_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in
	input wire logic level,
	// Edge pulses
	output logic rise,
	output logic fall,
	output logic change
);
	typedef struct packed {
		logic last;
	} ubi_edge_s;
	ubi_edge_s state_r;
	ubi_edge_s state_nxt;
	always_comb begin
		state_nxt.last = level;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end
	assign rise = level & ~state_r.last;
	assign fall = ~level & state_r.last;
	assign change = level ^ state_r.last;
endmodule // ubi_edge_detect

// ===== logic/ubi_reg_read_mux.sv
// Read data selection for the interrupt registers
`timescale 1ns/1ps
module ubi_reg_read_mux (
	// Address
	input wire logic [ubi_pkg::ADDR_W-1:0] addr,
	// Register contents
	input wire logic [31:0] statusView,
	input wire logic [31:0] enableView,
	input wire logic [31:0] eventView,
	// Result
	output logic [31:0] data
);
	import ubi_pkg::*;
	always_comb begin
		case (addr)
			OFF_STATUS: begin
				data = statusView;
			end
			OFF_ENABLE: begin
				data = enableView;
			end
			OFF_EVENT: begin
				data = eventView;
			end
			default: begin
				data = RESERVED_READ;
			end
		endcase
	end
endmodule // ubi_reg_read_mux

// ===== logic/ubi_irq_status_enable.sv
// Interrupt status, enable and clear logic of the USB device bridge
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module ubi_irq_status_enable (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [ubi_pkg::ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	// Core flag outputs, bits 7..0 in status order
	input wire logic [7:0] coreFlags,
	input wire logic coreBusReset,
	input wire logic coreSuspend,
	// Bridge event pulses
	input wire logic coreRegReadDone,
	input wire logic ctrlRegReadDone,
	input wire logic powerDetect,
	input wire logic writeError,
	input wire logic [6:0] xferEvents,
	// Interrupt
	output logic irq
);
	import ubi_pkg::*;

	typedef struct packed {
		logic [31:0] status;
		logic [31:0] enable;
		logic [31:0] rdData;
		logic irq;
	} ubi_state_s;

	ubi_state_s state_r;
	ubi_state_s state_nxt;
	logic busResetRise;
	logic busResetFall;
	logic suspendChange;
	logic [31:0] events;
	logic [31:0] statusView;
	logic [31:0] muxData;

	function automatic logic [31:0] pending(input logic [31:0] st, input logic [31:0] en);
		pending = st & en;
	endfunction

	ubi_edge_detect busResetEdge (
		.clk(clk),
		.rst(rst),
		.level(coreBusReset),
		.rise(busResetRise),
		.fall(busResetFall),
		.change()
	);

	ubi_edge_detect suspendEdge (
		.clk(clk),
		.rst(rst),
		.level(coreSuspend),
		.rise(),
		.fall(),
		.change(suspendChange)
	);

	always_comb begin
		events = '0;
		events[BIT_BUS_RESET_END] = busResetFall;
		events[BIT_BUS_RESET] = busResetRise;
		events[BIT_SUSPEND_CHG] = suspendChange;
		events[BIT_CORE_RD_DONE] = coreRegReadDone;
		events[BIT_CTRL_RD_DONE] = ctrlRegReadDone;
		events[BIT_POWER_DETECT] = powerDetect;
		events[BIT_WRITE_ERROR] = writeError;
		events[23:17] = xferEvents;
	end

	// Live flags are never latched here; clearing happens in the core
	assign statusView = (state_r.status & STICKY_MASK) | {24'h000000, coreFlags};

	ubi_reg_read_mux readMux (
		.addr(regAddr),
		.statusView(statusView),
		.enableView(state_r.enable),
		.eventView(statusView & state_r.enable),
		.data(muxData)
	);

	always_comb begin
		state_nxt = state_r;
		state_nxt.rdData = '0;
		if (regRdStb) begin
			state_nxt.rdData = muxData;
		end
		if (regWrStb && regAddr == OFF_ENABLE) begin
			state_nxt.enable = regWrData & ENABLE_MASK;
		end
		// Set wins over clear so an event in the clearing cycle is kept
		if (regWrStb && regAddr == OFF_CLEAR) begin
			state_nxt.status = state_r.status & ~(regWrData & STICKY_MASK);
		end
		state_nxt.status = (state_nxt.status | events) & STICKY_MASK;
		// Irq follows the visible state, one cycle behind its inputs
		state_nxt.irq = |pending(statusView, state_r.enable);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r.status <= STATUS_RESET;
			state_r.enable <= ENABLE_RESET;
			state_r.rdData <= '0;
			state_r.irq <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign regRdData = state_r.rdData;
	assign irq = state_r.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	live_ep_copy_a: assert property (regRdStb && regAddr == OFF_STATUS |=> regRdData[BIT_EP] == $past(coreFlags[6]))
		else $error("endpoint flag copy wrong");
	live_flags_copy_a: assert property (regRdStb && regAddr == OFF_STATUS |=> regRdData[5:0] == $past(coreFlags[5:0]))
		else $error("core flag copies wrong");
	zero_rx_copy_a: assert property (regRdStb && regAddr == OFF_STATUS |=> regRdData[BIT_ZERO_RX] == $past(coreFlags[3]))
		else $error("zero rx copy wrong");
	rd_done_gate_a: assert property (ctrlRegReadDone && state_r.enable[BIT_CTRL_RD_DONE] |=> ##1 irq)
		else $error("read done did not raise irq");
	xfer_gate_a: assert property (|(xferEvents & state_r.enable[23:17]) |=> ##1 irq)
		else $error("transfer event did not raise irq");
	err_power_gate_a: assert property ((writeError && state_r.enable[BIT_WRITE_ERROR]) || (powerDetect && state_r.enable[BIT_POWER_DETECT]) |=> ##1 irq)
		else $error("error or power event did not raise irq");
	enable_hold_a: assert property (!(regWrStb && regAddr == OFF_ENABLE) |=> $stable(state_r.enable))
		else $error("enable changed without write");
	enable_write_a: assert property (regWrStb && regAddr == OFF_ENABLE |=> state_r.enable == ($past(regWrData) & ENABLE_MASK))
		else $error("enable write wrong");
	reset_end_set_a: assert property (busResetFall |=> state_r.status[BIT_BUS_RESET_END])
		else $error("bus reset end not set");
	suspend_sticky_a: assert property (state_r.status[BIT_SUSPEND_CHG] && !(regWrStb && regAddr == OFF_CLEAR) |=> state_r.status[BIT_SUSPEND_CHG])
		else $error("suspend change bit lost");
	irq_level_a: assert property (irq == $past(|(statusView & state_r.enable)))
		else $error("irq level mismatch");

	bus_reset_cov_c: cover property (busResetRise ##[1:20] busResetFall);
	irq_raise_cov_c: cover property (!irq ##1 irq);
	clear_cov_c: cover property (state_r.status[BIT_SUSPEND_CHG] ##1 regWrStb && regAddr == OFF_CLEAR ##1 !state_r.status[BIT_SUSPEND_CHG]);
	live_irq_cov_c: cover property (coreFlags[BIT_EP] && state_r.enable == '0);
endmodule // ubi_irq_status_enable

// ===== verification/ubi_core_model.sv
// Behavioural model of the USB core flag outputs
`timescale 1ns/1ps
module ubi_core_model (
	// Clock
	input wire logic clk,
	// Bench requests
	input wire logic [7:0] flagSet,
	input wire logic [7:0] flagClr,
	input wire logic busRstReq,
	input wire logic suspReq,
	// Core levels
	output logic [7:0] coreFlags = 8'h00,
	output logic coreBusReset = 1'b0,
	output logic coreSuspend = 1'b0
);
	// Flags clear only in the core's own registers
	always @(posedge clk) begin
		coreFlags <= (coreFlags & ~flagClr) | flagSet;
		coreBusReset <= busRstReq;
		coreSuspend <= suspReq;
	end
endmodule // ubi_core_model

// ===== verification/tb_ubi_irq_status_enable.sv
// Self-checking bench of the USB bridge interrupt block
`timescale 1ns/1ps
module tb_ubi_irq_status_enable;
	import ubi_pkg::*;
	logic clk = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, rdWas = 1'b0, irq;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, expQ[$];
	logic [7:0] coreFlags, flagSet = 8'h0, flagClr = 8'h0, f;
	logic coreBusReset, coreSuspend, busRstReq = 1'b0, suspReq = 1'b0;
	logic evCore = 1'b0, evCtrl = 1'b0, evPow = 1'b0, evWerr = 1'b0;
	logic [6:0] xferEv = 7'h0;
	int errors = 0, checks_done = 0, seed = 57;
	initial forever #10 clk = ~clk;
	ubi_core_model core (.clk(clk), .flagSet(flagSet), .flagClr(flagClr), .busRstReq(busRstReq),
		.suspReq(suspReq), .coreFlags(coreFlags), .coreBusReset(coreBusReset), .coreSuspend(coreSuspend));
	ubi_irq_status_enable dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .coreFlags(coreFlags),
		.coreBusReset(coreBusReset), .coreSuspend(coreSuspend), .coreRegReadDone(evCore),
		.ctrlRegReadDone(evCtrl), .powerDetect(evPow), .writeError(evWerr), .xferEvents(xferEv), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkIrq(input logic e);
		repeat (3) @(posedge clk);
		#1 chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		expQ.push_back(e);
		@(posedge clk);
		regRdStb <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rdWas) chk(regRdData, expQ.pop_front());
		rdWas <= regRdStb;
	end
	task automatic wrap_up;
		$display("Checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		wrap_up;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_ENABLE, ENABLE_RESET);
		rd(OFF_STATUS, STATUS_RESET);
		wr(OFF_ENABLE, 32'hffff_ffff);
		rd(OFF_ENABLE, ENABLE_MASK);
		wr(OFF_ENABLE, 32'h0);
		f = $random(seed);
		@(posedge clk);
		{evWerr, evPow, evCtrl, evCore, xferEv, flagSet} <= {11'h7ff, f};
		busRstReq <= 1'b1;
		suspReq <= 1'b1;
		@(posedge clk);
		{evWerr, evPow, evCtrl, evCore, xferEv, flagSet} <= 19'h0;
		busRstReq <= 1'b0;
		repeat (3) @(posedge clk);
		rd(OFF_STATUS, 32'h33fe_0700 | {24'h0, f});
		chkIrq(1'b0);
		// Each gate alone, so a crossed enable bit shows up
		for (int i = 8; i < 30; i++) begin
			if (ENABLE_MASK[i]) begin
				wr(OFF_ENABLE, 32'h1 << i);
				chkIrq(1'b1);
				wr(OFF_CLEAR, 32'h1 << i);
				chkIrq(1'b0);
			end
		end
		rd(OFF_STATUS, {24'h0, f});
		@(posedge clk);
		busRstReq <= 1'b1;
		suspReq <= 1'b0;
		repeat (3) @(posedge clk);
		rd(OFF_STATUS, 32'h300 | {24'h0, f});
		flagClr <= f;
		@(posedge clk);
		flagClr <= 8'h0;
		rd(OFF_STATUS, 32'h300);
		wr(OFF_ENABLE, 32'h0100_0000);
		wr(4'h2, 32'hffff_ffff);
		rd(OFF_ENABLE, 32'h0100_0000);
		rd(4'h2, 32'h0);
		// Events with their gates open, so the gate assertions see their triggers
		wr(OFF_CLEAR, 32'hffff_ffff);
		wr(OFF_ENABLE, 32'hffff_ffff);
		@(posedge clk);
		{evWerr, evPow, evCtrl, evCore, xferEv} <= 11'h7ff;
		@(posedge clk);
		{evWerr, evPow, evCtrl, evCore, xferEv} <= 11'h0;
		rd(OFF_EVENT, 32'h33fe_0000);
		chkIrq(1'b1);
		rd(OFF_CLEAR, 32'h0);
		// Clear and event in one cycle: the event must survive
		@(posedge clk);
		regAddr <= OFF_CLEAR;
		regWrData <= 32'hffff_ffff;
		regWrStb <= 1'b1;
		evPow <= 1'b1;
		@(posedge clk);
		regWrStb <= 1'b0;
		evPow <= 1'b0;
		rd(OFF_STATUS, 32'h1000_0000);
		chkIrq(1'b1);
		repeat (3) @(posedge clk);
		wrap_up;
	end
endmodule // tb_ubi_irq_status_enable
